// ===== design/tlsw_core.sv
// Purpose: Interprets each fetched list command/status word and writes
//          back the completion code word once a frame has been stripped
// Assumes: List fetch, frame send and ring strip are done by neighbours;
//          this block sees one fetched word at a time with valid/ready
// Notes:   One writeback per frame, only to the frame's first list
`timescale 1ns/1ps

module tlsw_core
  import tlsw_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_sys_rst,
  input  wire tlsw_apb_req_t i_apb,
  output tlsw_apb_rsp_t      o_apb,
  input  wire tlsw_list_t    i_list,
  output logic               o_list_ready,
  output logic               o_list_refetch,
  output logic               o_send_start,
  output logic               o_send_last,
  input  wire logic          i_strip_done,
  input  wire logic [7:0]    i_returned_status_byte_copy,
  input  wire logic          i_strip_err,
  output tlsw_wb_t           o_wb,
  input  wire logic          i_wb_ready,
  output logic               o_irq
);

  // All state of the block lives in one register; r_d is its next value
  typedef struct packed {
    tlsw_state_t           st;          // Position in the frame walk
    logic                  enable;      // Software run bit
    logic [15:0]           req_word;    // Request word of the first list
    logic                  chain_end;   // Last taken list closes the chain
    logic [15:0]           last_wb;     // Last completion word written
    logic [15:0]           count;       // Frames completed, wraps
    logic [IRQ_W-1:0]      irq_stat;    // Sticky event bits
    logic [IRQ_W-1:0]      irq_mask;    // Event enables
    tlsw_wb_t              wb;          // Pending completion write
    logic                  send_start;  // Pulse: frame start accepted
    logic                  send_last;   // Pulse: frame end list taken
    logic                  refetch;     // Pulse: first list not yet valid
  } tlsw_regs_t;

  tlsw_regs_t       r_q;
  tlsw_regs_t       r_d;

  logic             apb_acc;     // Access phase of any transfer
  logic             apb_wr;      // Access phase of a write
  logic             apb_rd;      // Access phase of a read
  logic             irq_rd;      // Read of the event register
  logic             list_take;   // A fetched list is consumed
  logic             list_stale;  // First list fetched with valid low
  logic [7:0]       fs_copy;     // Returned status byte, top bits cut
  logic [15:0]      cmp;         // Completion code word
  logic [IRQ_W-1:0] ev;          // Events raised in this cycle
  logic [31:0]      rdata;       // Read mux output
  logic             hit;         // Address maps to a register

  // Zero-wait slave: every access phase is answered in the same cycle,
  // so no wait counter is needed and back-to-back transfers are fine
  assign apb_acc = i_apb.psel & i_apb.penable;
  assign apb_wr  = apb_acc & i_apb.pwrite;
  assign apb_rd  = apb_acc & ~i_apb.pwrite;
  assign irq_rd  = apb_rd & (i_apb.paddr == OFF_IRQ);

  // Lists are looked at only while a frame may be started or continued
  assign o_list_ready = (r_q.st == ST_WAIT_VALID) || (r_q.st == ST_SEND);

  // first list needs valid
  // Continuation lists are never stalled on their valid bit: only the
  // anticipated start of a frame carries a meaningful one
  assign list_stale = (r_q.st == ST_WAIT_VALID) & i_list.valid
                    & ~i_list.word[BIT_VALID];
  assign list_take  = o_list_ready & i_list.valid
                    & (i_list.word[BIT_VALID] | (r_q.st == ST_SEND));

  // status byte copy
  // One slot per status bit; the keep mask ties the top two low
  for (genvar gi = 0; gi < 8; gi++) begin : g_fs
    assign fs_copy[gi] = i_returned_status_byte_copy[gi] & FS_KEEP_MASK[gi];
  end

  // Completion word built from the held request plus the strip result
  always_comb begin
    cmp = 16'h0000;
    cmp[BIT_VALID]     = 1'b0;
    cmp[BIT_COMPLETE]  = 1'b1;
    cmp[BIT_SOF]       = 1'b1;
    cmp[BIT_EOF]       = r_q.req_word[BIT_EOF];
    cmp[BIT_FINT]      = r_q.req_word[BIT_FINT];
    cmp[RSV_HI:RSV_LO] = r_q.req_word[RSV_HI:RSV_LO];
    cmp[BIT_TXERR]     = i_strip_err;
    // The byte stands even on error; the host decides whether to use it
    cmp[FS_HI:FS_LO]   = fs_copy;
  end

  // Read mux; unmapped offsets answer zero with an error response
  always_comb begin
    hit = 1'b1;
    unique case (i_apb.paddr)
      OFF_CTRL:   rdata = {31'h0, r_q.enable};
      OFF_STATUS: rdata = {29'h0, r_q.st};
      // Event bits: frame done, chain end, transmit error
      OFF_IRQ:    rdata = {29'h0, r_q.irq_stat};
      OFF_MASK:   rdata = {29'h0, r_q.irq_mask};
      OFF_LAST:   rdata = {16'h0, r_q.last_wb};
      // Counter wraps at 16 bits; software should work with differences
      OFF_COUNT:  rdata = {16'h0, r_q.count};
      default: begin
        rdata = 32'h0000_0000;
        hit   = 1'b0;
      end
    endcase
  end

  always_comb begin
    r_d            = r_q;
    ev             = '0;
    // Pulses last one cycle unless raised again below
    r_d.send_start = 1'b0;
    r_d.send_last  = 1'b0;
    r_d.refetch    = 1'b0;

    unique case (r_q.st)
      ST_IDLE: begin
        // Leaves idle only once software sets the run bit
        if (r_q.enable) begin
          r_d.st = ST_WAIT_VALID;
        end
      end

      ST_WAIT_VALID: begin
        if (list_stale) begin
          // Ask the fetch side to read the same list again
          r_d.refetch = 1'b1;
        end else if (list_take) begin
          r_d.req_word   = i_list.word;
          r_d.chain_end  = i_list.last_in_chain;
          r_d.send_start = 1'b1;
          r_d.send_last  = i_list.word[BIT_EOF];
          if (i_list.word[BIT_EOF]) begin
            r_d.st = ST_WAIT_STRIP;
          end else begin
            r_d.st = ST_SEND;
          end
        end
      end

      ST_SEND: begin
        // continuation words are read only
        // Their request bits are not kept: only the first list is written
        if (list_take) begin
          r_d.chain_end = i_list.last_in_chain;
          if (i_list.word[BIT_EOF]) begin
            r_d.send_last = 1'b1;
            r_d.st        = ST_WAIT_STRIP;
          end
        end
      end

      ST_WAIT_STRIP: begin
        // wait for strip result
        // Composing the word only here keeps a half-known status byte
        // from ever reaching host memory
        if (i_strip_done) begin
          r_d.wb.valid  = 1'b1;
          r_d.wb.word   = cmp;
          r_d.st        = ST_WRITE;
          ev[IRQ_TXERR] = i_strip_err;
        end
      end

      ST_WRITE: begin
        // Word and valid stand unchanged until host memory takes them
        if (i_wb_ready) begin
          r_d.wb.valid  = 1'b0;
          r_d.last_wb   = r_q.wb.word;
          r_d.count     = r_q.count + 16'h0001;
          ev[IRQ_FRAME] = r_q.wb.word[BIT_FINT] & r_q.req_word[BIT_SOF];
          ev[IRQ_CHAIN] = r_q.chain_end;
          // A cleared run bit stops the walk between frames only
          if (r_q.chain_end | ~r_q.enable) begin
            r_d.st = ST_IDLE;
          end else begin
            r_d.st = ST_WAIT_VALID;
          end
        end
      end

      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // Set wins over the clear-on-read, so an event in the read cycle
    // is reported by the next read rather than lost
    if (irq_rd) begin
      r_d.irq_stat = ev;
    end else begin
      r_d.irq_stat = r_q.irq_stat | ev;
    end

    // Register writes land at the access edge only
    if (apb_wr && (i_apb.paddr == OFF_CTRL)) begin
      r_d.enable = i_apb.pwdata[0];
    end
    if (apb_wr && (i_apb.paddr == OFF_MASK)) begin
      r_d.irq_mask = i_apb.pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r_q          <= '0;
      r_q.st       <= ST_IDLE;
      r_q.req_word <= RST_WORD;
      r_q.last_wb  <= RST_WORD;
      r_q.count    <= RST_COUNT;
    end else begin
      r_q <= r_d;
    end
  end

  // Handshake answers are combinational; the rest comes from flip-flops
  always_comb begin
    o_apb.pready  = apb_acc;
    o_apb.pslverr = apb_acc & ~hit;
    if (apb_rd) begin
      o_apb.prdata = rdata;
    end else begin
      o_apb.prdata = 32'h0000_0000;
    end
  end

  assign o_list_refetch = r_q.refetch;
  assign o_send_start   = r_q.send_start;
  assign o_send_last    = r_q.send_last;
  assign o_wb           = r_q.wb;
  // Level interrupt: any unmasked sticky event
  assign o_irq          = |(r_q.irq_stat & r_q.irq_mask);

endmodule : tlsw_core

// ===== design/tlsw_pkg.sv
// Purpose: Shared constants and types for transmit list status writeback
// Assumes: 16-bit list command/status words, APB register access
// Notes:   Bit positions of request and completion words, register map
package tlsw_pkg;

  localparam int unsigned BIT_VALID    = 0;
  localparam int unsigned BIT_COMPLETE = 1;
  localparam int unsigned BIT_SOF      = 2;
  localparam int unsigned BIT_EOF      = 3;
  localparam int unsigned BIT_FINT     = 4;
  localparam int unsigned BIT_TXERR    = 5;
  localparam int unsigned RSV_LO       = 6;
  localparam int unsigned RSV_HI       = 7;
  localparam int unsigned FS_LO        = 8;
  localparam int unsigned FS_HI        = 15;
  localparam logic [7:0]  FS_KEEP_MASK = 8'h3F;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ    = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0C;
  localparam logic [7:0] OFF_LAST   = 8'h10;
  localparam logic [7:0] OFF_COUNT  = 8'h14;

  localparam int unsigned IRQ_FRAME  = 0;
  localparam int unsigned IRQ_CHAIN  = 1;
  localparam int unsigned IRQ_TXERR  = 2;
  localparam int unsigned IRQ_W      = 3;

  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_VALID, ST_SEND, ST_WAIT_STRIP, ST_WRITE
  } tlsw_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tlsw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tlsw_apb_rsp_t;

  // Fetched list: command/status word plus chain position
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        last_in_chain;
  } tlsw_list_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } tlsw_wb_t;

endpackage : tlsw_pkg

// ===== tb/tlsw_chk_sva.sv
// Purpose: assertions on list and writeback ports
// Assumes: one clock, synchronous reset
// Notes:   bound to tlsw_core below
`timescale 1ns/1ps
module tlsw_chk import tlsw_pkg::*; (
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire tlsw_list_t i_list,
  input wire logic       o_list_refetch,
  input wire logic       o_send_start,
  input wire logic       i_strip_done,
  input wire logic [7:0] i_returned_status_byte_copy,
  input wire logic       i_strip_err,
  input wire tlsw_wb_t   o_wb,
  input wire logic       i_wb_ready
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_start_valid:
    assert property (o_send_start |-> $past(i_list.word[0]))
    else $error("start on invalid list");
  a_low_bits:
    assert property (o_wb.valid |-> o_wb.word[2:0] == 3'h6)
    else $error("bad low bits");
  a_fs_top_zero:
    assert property (o_wb.valid |-> o_wb.word[15:14] == 2'h0)
    else $error("status top bits set");
  a_wb_after_strip:
    assert property ($rose(o_wb.valid) |-> $past(i_strip_done))
    else $error("writeback before strip");
  a_err_copy:
    assert property ($rose(o_wb.valid) |-> o_wb.word[5] == $past(i_strip_err))
    else $error("bad error bit");
  a_fs_copy:
    assert property ($rose(o_wb.valid) |->
      o_wb.word[15:8] == ($past(i_returned_status_byte_copy) & FS_KEEP_MASK))
    else $error("bad status byte");
  a_wb_hold:
    assert property (o_wb.valid && !i_wb_ready |=> o_wb.valid && $stable(o_wb))
    else $error("writeback dropped");
  a_single_wb:
    assert property (o_wb.valid && i_wb_ready |=> !o_wb.valid)
    else $error("second writeback");
  cover property (o_list_refetch);
  cover property (o_wb.valid && !i_wb_ready);
  cover property (o_wb.valid && i_wb_ready && o_wb.word[5]);
endmodule : tlsw_chk
bind tlsw_core tlsw_chk u_chk (.*);

// ===== tb/tlsw_host.sv
// Purpose: host memory serving lists and taking writebacks
// Assumes: bench queues lists as {last_in_chain, word}
// Notes:   slow mode accepts writebacks every fourth cycle
`timescale 1ns/1ps
module tlsw_host import tlsw_pkg::*; (
  input  wire logic     i_ref_clk,
  input  wire logic     i_slow,
  input  wire logic     o_list_ready,
  input  wire logic     o_list_refetch,
  input  wire tlsw_wb_t o_wb,
  output tlsw_list_t    i_list,
  output logic          i_wb_ready
);
  logic [16:0] q[$];
  logic [15:0] got[$];
  logic [1:0]  cnt = 2'h0;
  logic        first = 1'h1;
  initial i_list = '0;
  initial i_wb_ready = 1'h0;
  always @(posedge i_ref_clk) begin
    cnt <= cnt + 2'h1;
    if (o_list_refetch)
      q[0][0] = 1'h1;
    if (o_list_ready && i_list.valid && (i_list.word[0] || !first)) begin
      first = i_list.word[3];
      void'(q.pop_front());
    end
    // Idle word flips so stale data never looks fresh
    i_list <= q.size() ? {1'h1, q[0][15:0], q[0][16]}
                       : {1'h0, ~i_list.word, 1'h0};
    i_wb_ready <= o_wb.valid && (!i_slow || cnt == 2'h3);
    if (o_wb.valid && i_wb_ready)
      got.push_back(o_wb.word);
  end
endmodule : tlsw_host

// ===== tb/tlsw_core_tb.sv
// Purpose: self-checking bench for tlsw_core
// Assumes: zero-wait APB slave, host model feeds lists
// Notes:   expected words built from request and strip inputs
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tlsw_core_tb import tlsw_pkg::*; ;
  logic          i_ref_clk = 1'h0;
  logic          i_sys_rst = 1'h1;
  logic          i_slow = 1'h0;
  tlsw_apb_req_t i_apb = '0;
  tlsw_apb_rsp_t o_apb;
  tlsw_list_t    i_list;
  tlsw_wb_t      o_wb;
  logic          o_list_ready, o_list_refetch, o_send_start, o_send_last;
  logic          i_strip_done = 1'h0, i_strip_err = 1'h0, i_wb_ready, o_irq;
  logic [7:0]    i_returned_status_byte_copy = 8'h00;
  logic [15:0]   lfsr = 16'h0021;
  logic [32:0]   rd;
  int            fails = 0, tests_run = 0, cyc = 0;
  int            starts = 0, frames = 0;
  tlsw_core DUT (.*);
  tlsw_host HOST (.*);
  initial forever #50 i_ref_clk = ~i_ref_clk;
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : rnd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_apb <= '{1'h1, 1'h0, w, a, d};
    @(posedge i_ref_clk);
    i_apb.penable <= 1'h1;
    do @(posedge i_ref_clk); while (o_apb.pready !== 1'h1);
    rd = {o_apb.pslverr, o_apb.prdata};
    i_apb <= '0;
  endtask : apb
  task automatic frame(input logic inv);
    logic [15:0] r, c, m, w;
    lfsr = rnd(lfsr);
    // start list; bits 6-7 left clear
    r = {8'h00, 2'h0, 1'h0, lfsr[4], !lfsr[0], 2'h2, !inv};
    HOST.q.push_back({1'h0, r});
    // end list with a stray per-frame bit
    if (lfsr[0])
      HOST.q.push_back({1'h0, 8'h00, 8'h18});
    do @(posedge i_ref_clk); while (o_send_last !== 1'h1);
    i_strip_done <= 1'h1;
    i_returned_status_byte_copy <= lfsr[15:8];
    i_strip_err <= lfsr[1];
    @(posedge i_ref_clk);
    i_strip_done <= 1'h0;
    c = {2'h0, lfsr[13:8], r[7:6], lfsr[1], r[4:3], 3'h6};
    m = lfsr[1] ? 16'h00FF : 16'hFFFF;
    do @(posedge i_ref_clk); while (HOST.got.size() == 0);
    w = HOST.got.pop_front();
    `CHK(w & m, c & m)
    `CHK(w[2:0], 3'h6)
    frames++;
    `CHK(starts, frames)
    repeat (3) @(posedge i_ref_clk);
    `CHK(o_irq, r[4])
    apb(1'h0, OFF_IRQ, 32'h0);
    `CHK(rd[IRQ_FRAME], r[4])
    repeat (2) @(posedge i_ref_clk);
    `CHK(o_irq, 1'h0)
    `CHK(HOST.got.size(), 0)
  endtask : frame
  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_send_start === 1'h1)
      starts++;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    apb(1'h1, OFF_CTRL, 32'h1);
    apb(1'h1, OFF_MASK, 32'h1);
    apb(1'h0, 8'h40, 32'h0);
    `CHK(rd, {1'h1, 32'h0})
    for (int i = 0; i < 8; i++) begin
      i_slow <= i[1];
      frame(i == 2);
    end
    apb(1'h0, OFF_COUNT, 32'h0);
    `CHK(rd[15:0], 16'h0008)
    end_sim;
  end
endmodule : tlsw_core_tb
